// ==== core/can_rx_consts.vh ====
// Constants for the CAN receive buffer status and identifier block
`ifndef CAN_RX_CONSTS_VH
`define CAN_RX_CONSTS_VH
// APB byte addresses
`define OFS_BUF0_CTRL 5'h00
`define OFS_BUF1_CTRL 5'h04
`define OFS_B0_ID_HI 5'h08
`define OFS_B0_ID_LO 5'h0c
`define OFS_B1_ID_HI 5'h10
`define OFS_B1_ID_LO 5'h14
`define OFS_FUNC_MODE 5'h18
`define OFS_INT_REQ 5'h1c
// Control register fields
`define CTL_FULL 7
`define CTL_MODE_HI 6
`define CTL_MODE_LO 5
`define CTL_DBEN 2
// Functional mode and interrupt flag bit positions
`define FM_ENH 0
`define INT_BUF0 0
`define INT_BUF1 1
// Legacy receive mode codes
`define RXM_ALL 2'h3
`define RXM_EXT 2'h2
`define RXM_STD 2'h1
`define RXM_FILT 2'h0
// Filter hit boundary between buffers and code width
`define HIT_W 5
`define HIT_BUF1_FIRST 5'h02
// Reset values
`define RST_MODE 1'h0
`define RST_HIT 5'h00
`define RST_ID 29'h0000000
`define RST_WORD 32'h00000000
`define RST_PAIR 2'h0
`endif

// ==== core/can_rx_accept.v ====
// Acceptance decision for one receive buffer
`timescale 1ns/1ps
module can_rx_accept (
  // Mode selection
  input wire enh_mode,
  input wire mode_hi,
  input wire mode_lo,
  // Frame attributes from the protocol engine
  input wire frame_err,
  input wire frame_ext,
  input wire filt_match,
  input wire filt_ext_sel,
  // Decision
  output reg accept
);
`include "can_rx_consts.vh"

  // Legacy uses two mode bits, enhanced only the upper one
  always @* begin
    accept = 1'b0;
    if (enh_mode) begin
      accept = mode_hi | (!frame_err & filt_match); // [R8]
    end else begin
      case ({mode_hi, mode_lo})
        `RXM_ALL: accept = 1'b1; // [R4]
        `RXM_EXT: accept = !frame_err & frame_ext & filt_match & filt_ext_sel; // [R5]
        `RXM_STD: accept = !frame_err & !frame_ext & filt_match & !filt_ext_sel; // [R6]
        `RXM_FILT: accept = !frame_err & filt_match & (filt_ext_sel == frame_ext); // [R7]
        default: accept = 1'b0;
      endcase
    end
  end
endmodule // can_rx_accept

// ==== core/can_rx_buffer_status_id.v ====
// Status, control and identifier holding for the two CAN receive buffers
// Operation
// [R1] Full flag set on store, software clears
// [R2] Full buffer never takes a new message
// [R3] Buffer 0 interrupt flag re-sets while full
// [R4] Legacy mode 11 accepts everything, errors too
// [R5] Legacy mode 10 valid extended, filter select one
// [R6] Legacy mode 01 valid standard, filter select zero
// [R7] Legacy mode 00 valid frames per filter select
// [R8] Enhanced single mode bit: all or filtered
// [R9] Remote request bit: legacy 3, enhanced 5
// [R10] Unimplemented bits read as zero
// [R11] Double buffering spills buffer 0 into 1
// [R12] Jump offset bit mirrors double-buffer enable
// [R13] Legacy buffer 0 one-bit filter hit
// [R14] Enhanced five-bit filter hit index per buffer
// [R15] Legacy buffer 1 three-bit filter hit code
// [R16] Identifier high byte: standard or extended bits
// [R17] Identifier low byte identifier bit placement
// [R18] Low byte bit 4 mirrors remote for standard
// [R19] Low byte bit 3 marks extended frames
// [R20] Control layout follows selected functional mode
`timescale 1ns/1ps
module can_rx_buffer_status_id (
  // Clock and reset
  input wire clk,
  input wire reset_n,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] paddr,
  input wire [31:0] pwdata,
  output wire pready,
  output reg [31:0] prdata,
  output reg pslverr,
  // Received frame from the protocol engine, same clock
  input wire rx_valid,
  input wire [28:0] rx_ident,
  input wire rx_ext,
  input wire rx_rtr,
  input wire rx_err,
  input wire rx_filter_match,
  input wire [4:0] rx_filter_hit,
  input wire rx_filter_ext_sel,
  // Load report
  output reg rx_stored,
  output reg rx_stored_buf,
  // Buffer state for the rest of the module
  output wire buf0_full,
  output wire buf1_full,
  output wire rx0_int_flag
);
`include "can_rx_consts.vh"

  // Configuration and per-buffer state
  reg enh_mode_reg;
  reg dben_reg;
  reg [1:0] mode_hi_reg;
  reg [1:0] mode_lo_reg;
  reg [1:0] full_reg;
  reg [1:0] rtr_reg;
  reg [1:0] ext_reg;
  reg [4:0] hit_reg [0:1];
  reg [28:0] id_reg [0:1];
  reg [1:0] int_reg;
  reg [1:0] full_next;
  reg [1:0] int_next;
  reg [1:0] load;
  reg [4:0] load_hit [0:1];
  reg [31:0] rdata_next;
  reg err_next;
  wire [1:0] acc;
  wire wr_en;
  wire rd_setup;
  wire to_buf0;
  wire sel_ctrl0;
  wire sel_ctrl1;
  wire sel_id0_hi;
  wire sel_id0_lo;
  wire sel_id1_hi;
  wire sel_id1_lo;
  wire sel_mode;
  wire sel_int;
  wire wr_ctrl0;
  wire wr_ctrl1;
  wire wr_mode;
  wire wr_int;
  integer i;
  integer j;
  genvar g;

  // Register a word select: low address bits match, all upper bits zero
  function hit_addr;
    input [31:0] addr;
    input [4:0] ofs;
    begin
      hit_addr = (addr[4:0] == ofs) && (addr[31:5] == 27'h0);
    end
  endfunction

  // Control byte in the layout of the active functional mode
  function [7:0] ctrl_view;
    input enh;
    input b1;
    input full;
    input mhi;
    input mlo;
    input rtr;
    input dben;
    input [4:0] hit;
    begin
      if (enh) begin
        // Enhanced: remote flag moves up, five hit bits
        ctrl_view = {full, mhi, rtr, hit}; // [R20] [R9] [R14]
      end else if (!b1) begin
        // Legacy buffer 0: enable and its read-only copy
        ctrl_view = {full, mhi, mlo, 1'b0, rtr, dben, dben, hit[0]}; // [R10] [R12] [R13]
      end else begin
        // Legacy buffer 1: three-bit hit code
        ctrl_view = {full, mhi, mlo, 1'b0, rtr, hit[2:0]}; // [R10] [R15]
      end
    end
  endfunction

  // Identifier high byte
  function [7:0] id_hi_view;
    input ext;
    input [28:0] id;
    begin
      id_hi_view = ext ? id[28:21] : id[10:3]; // [R16]
    end
  endfunction

  // Identifier low byte; bit 2 unimplemented
  function [7:0] id_lo_view;
    input ext;
    input rtr;
    input [28:0] id;
    begin
      id_lo_view = {(ext ? id[20:18] : id[2:0]), // [R17]
                    (ext ? 1'b0 : rtr), // [R18]
                    ext, // [R19]
                    1'b0, // [R10]
                    (ext ? id[17:16] : 2'b00)}; // [R17]
    end
  endfunction

  // Zero wait state; read data is latched in the setup cycle
  assign pready = 1'b1;
  assign wr_en = psel & penable & pwrite;
  assign rd_setup = psel & !penable;
  assign buf0_full = full_reg[0];
  assign buf1_full = full_reg[1];
  assign rx0_int_flag = int_reg[0];

  // Word selects, one compare per register for reads and writes
  assign sel_ctrl0 = hit_addr(paddr, `OFS_BUF0_CTRL);
  assign sel_ctrl1 = hit_addr(paddr, `OFS_BUF1_CTRL);
  assign sel_id0_hi = hit_addr(paddr, `OFS_B0_ID_HI);
  assign sel_id0_lo = hit_addr(paddr, `OFS_B0_ID_LO);
  assign sel_id1_hi = hit_addr(paddr, `OFS_B1_ID_HI);
  assign sel_id1_lo = hit_addr(paddr, `OFS_B1_ID_LO);
  assign sel_mode = hit_addr(paddr, `OFS_FUNC_MODE);
  assign sel_int = hit_addr(paddr, `OFS_INT_REQ);

  // Write strobes; only the access phase commits a write
  assign wr_ctrl0 = wr_en & sel_ctrl0;
  assign wr_ctrl1 = wr_en & sel_ctrl1;
  assign wr_mode = wr_en & sel_mode;
  assign wr_int = wr_en & sel_int;

  // Filters below the boundary feed buffer 0, the rest buffer 1
  assign to_buf0 = rx_filter_hit < `HIT_BUF1_FIRST;

  // One acceptance check per buffer, each under its own mode bits
  generate
    for (g = 0; g < 2; g = g + 1) begin : gen_acc
      can_rx_accept u_accept (
        .enh_mode(enh_mode_reg),
        .mode_hi(mode_hi_reg[g]),
        .mode_lo(mode_lo_reg[g]),
        .frame_err(rx_err),
        .frame_ext(rx_ext),
        .filt_match(rx_filter_match),
        .filt_ext_sel(rx_filter_ext_sel),
        .accept(acc[g])
      );
    end
  endgenerate

  // Load steering; an occupied buffer is skipped, never overwritten
  always @* begin
    load = 2'h0;
    load_hit[0] = rx_filter_hit;
    load_hit[1] = rx_filter_hit;
    if (rx_valid) begin
      if (to_buf0) begin
        if (acc[0] && !full_reg[0]) begin // [R2]
          load[0] = 1'b1;
        end else if (acc[0] && !enh_mode_reg && dben_reg && !full_reg[1]) begin
          // Spill only in the legacy layout and into an empty buffer 1
          load[1] = 1'b1; // [R11]
        end
      end else if (acc[1] && !full_reg[1]) begin // [R2]
        load[1] = 1'b1;
      end
    end
    // Legacy hit codes keep only the documented width
    if (!enh_mode_reg) begin
      load_hit[0] = {4'h0, rx_filter_hit[0]}; // [R13]
      load_hit[1] = {2'h0, rx_filter_hit[2:0]}; // [R15]
    end
  end

  // Full and interrupt flags; the hardware set wins over a clear
  always @* begin
    full_next = full_reg;
    int_next = int_reg;
    // Software may only clear; a one in the full bit changes nothing
    if (wr_ctrl0 && !pwdata[`CTL_FULL]) begin
      full_next[0] = 1'b0; // [R1]
    end
    if (wr_ctrl1 && !pwdata[`CTL_FULL]) begin
      full_next[1] = 1'b0; // [R1]
    end
    if (wr_int) begin
      // Write zero clears; the buffer 0 flag stays up while buffer 0 is still full
      int_next[0] = int_reg[0] & (pwdata[`INT_BUF0] | full_reg[0]); // [R3]
      int_next[1] = int_reg[1] & pwdata[`INT_BUF1];
    end
    // Last, so a store in the clearing cycle is never lost
    for (i = 0; i < 2; i = i + 1) begin
      if (load[i]) begin
        full_next[i] = 1'b1; // [R1]
        int_next[i] = 1'b1;
      end
    end
  end

  // Full and interrupt flag registers
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      full_reg <= `RST_PAIR;
      int_reg <= `RST_PAIR;
    end else begin
      full_reg <= full_next;
      int_reg <= int_next;
    end
  end

  // Configuration registers, written by software only
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      enh_mode_reg <= `RST_MODE;
      dben_reg <= `RST_MODE;
      mode_hi_reg <= `RST_PAIR;
      mode_lo_reg <= `RST_PAIR;
    end else begin
      if (wr_mode) begin
        enh_mode_reg <= pwdata[`FM_ENH]; // [R20]
      end
      if (wr_ctrl0) begin
        mode_hi_reg[0] <= pwdata[`CTL_MODE_HI];
        // Bit 5 and bit 2 are status bits in the enhanced layout
        if (!enh_mode_reg) begin
          mode_lo_reg[0] <= pwdata[`CTL_MODE_LO]; // [R20]
          dben_reg <= pwdata[`CTL_DBEN]; // [R11]
        end
      end
      if (wr_ctrl1) begin
        mode_hi_reg[1] <= pwdata[`CTL_MODE_HI];
        if (!enh_mode_reg) begin
          mode_lo_reg[1] <= pwdata[`CTL_MODE_LO]; // [R20]
        end
      end
    end
  end

  // Captured message attributes, only written on a load
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rtr_reg <= `RST_PAIR;
      ext_reg <= `RST_PAIR;
      for (j = 0; j < 2; j = j + 1) begin
        hit_reg[j] <= `RST_HIT;
        id_reg[j] <= `RST_ID;
      end
    end else begin
      // Identifier kept whole; the byte views are cut at read time
      for (j = 0; j < 2; j = j + 1) begin
        if (load[j]) begin
          rtr_reg[j] <= rx_rtr; // [R9]
          ext_reg[j] <= rx_ext; // [R19]
          hit_reg[j] <= load_hit[j]; // [R14]
          id_reg[j] <= rx_ident;
        end
      end
    end
  end

  // Load report toward the protocol engine
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rx_stored <= 1'b0;
      rx_stored_buf <= 1'b0;
    end else begin
      rx_stored <= |load;
      rx_stored_buf <= load[1];
    end
  end

  // Read mux; unmapped addresses answer zero with an error
  always @* begin
    rdata_next = `RST_WORD;
    err_next = 1'b0;
    if (sel_ctrl0) begin
      rdata_next[7:0] = ctrl_view(enh_mode_reg, 1'b0, full_reg[0], mode_hi_reg[0],
                                  mode_lo_reg[0], rtr_reg[0], dben_reg, hit_reg[0]);
    end else if (sel_ctrl1) begin
      rdata_next[7:0] = ctrl_view(enh_mode_reg, 1'b1, full_reg[1], mode_hi_reg[1],
                                  mode_lo_reg[1], rtr_reg[1], dben_reg, hit_reg[1]);
    end else if (sel_id0_hi) begin
      rdata_next[7:0] = id_hi_view(ext_reg[0], id_reg[0]);
    end else if (sel_id0_lo) begin
      rdata_next[7:0] = id_lo_view(ext_reg[0], rtr_reg[0], id_reg[0]);
    end else if (sel_id1_hi) begin
      rdata_next[7:0] = id_hi_view(ext_reg[1], id_reg[1]);
    end else if (sel_id1_lo) begin
      rdata_next[7:0] = id_lo_view(ext_reg[1], rtr_reg[1], id_reg[1]);
    end else if (sel_mode) begin
      rdata_next[`FM_ENH] = enh_mode_reg;
    end else if (sel_int) begin
      rdata_next[1:0] = int_reg;
    end else begin
      err_next = 1'b1;
    end
  end

  // Data captured in setup so the access phase needs no wait state;
  // a load landing in that same cycle shows on the next read only
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      prdata <= `RST_WORD;
      pslverr <= 1'b0;
    end else if (rd_setup) begin
      prdata <= pwrite ? `RST_WORD : rdata_next;
      pslverr <= err_next;
    end
  end
endmodule // can_rx_buffer_status_id

// ==== dv/can_rx_buffer_status_id_monitor.sv ====
// Checker for the CAN receive buffer status block
`timescale 1ns/1ps
module can_rx_buffer_status_id_monitor (
  // Clock and reset
  input wire clk,
  input wire reset_n,
  // APB
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] paddr,
  input wire [31:0] pwdata,
  input wire pslverr,
  // Frame side
  input wire rx_valid,
  input wire rx_stored,
  input wire rx_stored_buf,
  input wire buf0_full,
  input wire buf1_full,
  input wire rx0_int_flag
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // Load and clear steps
  sequence load0_s;
    rx_stored && !rx_stored_buf;
  endsequence
  sequence load1_s;
    rx_stored && rx_stored_buf;
  endsequence
  sequence clr0_s;
    psel && penable && pwrite && paddr == 32'h0 && !pwdata[7];
  endsequence
  store_cause_a: assert property (rx_stored |-> $past(rx_valid))
    else $error("store without frame");
  load0_full_a: assert property (load0_s |-> buf0_full && rx0_int_flag)
    else $error("buffer 0 load not flagged");
  load1_full_a: assert property (load1_s |-> buf1_full)
    else $error("buffer 1 load not flagged");
  both_full_a: assert property (rx_valid && buf0_full && buf1_full |=> !rx_stored)
    else $error("load into full buffer");
  int_hold_a: assert property (buf0_full |-> rx0_int_flag)
    else $error("interrupt flag low while full");
  full_rise_a: assert property ($rose(buf0_full) |-> $past(rx_valid))
    else $error("full set without frame");
  full_clear_a: assert property (clr0_s |=> !buf0_full || rx_stored)
    else $error("full flag not cleared");
  bad_addr_a: assert property (psel && penable && paddr[31:5] != 0 |-> pslverr)
    else $error("unmapped access not refused");
endmodule // can_rx_buffer_status_id_monitor

bind can_rx_buffer_status_id can_rx_buffer_status_id_monitor u_mon (
  .clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pslverr(pslverr),
  .rx_valid(rx_valid), .rx_stored(rx_stored), .rx_stored_buf(rx_stored_buf),
  .buf0_full(buf0_full), .buf1_full(buf1_full), .rx0_int_flag(rx0_int_flag)
);

// ==== dv/can_rx_engine_model.sv ====
// Protocol engine stand-in that presents received frames
`timescale 1ns/1ps
module can_rx_engine_model (
  // Clock
  input wire clk,
  // Frame to the buffers
  output logic rx_valid,
  output logic [28:0] rx_ident,
  output logic [4:0] rx_flags,
  output logic [4:0] rx_filter_hit
);
  // Idle at start
  initial begin
    rx_valid = 1'b0;
    rx_ident = 29'h0;
    rx_flags = 5'h0;
    rx_filter_hit = 5'h0;
  end
  // One-cycle frame; flags are ext, rtr, err, filter select, match
  task send(input [28:0] id, input [4:0] f, input [4:0] hit);
    @(posedge clk);
    rx_valid <= 1'b1;
    rx_ident <= id;
    rx_flags <= f;
    rx_filter_hit <= hit;
    @(posedge clk);
    rx_valid <= 1'b0;
    // Fields flip after the frame so stale values never look valid
    rx_ident <= ~id;
    rx_flags <= ~f;
    rx_filter_hit <= ~hit;
  endtask
endmodule // can_rx_engine_model

// ==== dv/can_rx_buffer_status_id_tb_top.sv ====
// Self-checking bench for the CAN receive buffer status block
`timescale 1ns/1ps
`include "can_rx_consts.vh"
module can_rx_buffer_status_id_tb_top;
  // Bench signals
  logic clk, reset_n, psel, penable, pwrite, pready, pslverr, last_err;
  logic [31:0] paddr, pwdata, prdata, rd;
  logic rx_valid, rx_stored, rx_stored_buf, buf0_full, buf1_full, rx0_int_flag;
  logic [28:0] rx_ident;
  logic [4:0] fl, rx_filter_hit;
  int num_errors, n_tests;
  can_rx_buffer_status_id DUT (
    .clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .rx_valid(rx_valid), .rx_ident(rx_ident),
    .rx_ext(fl[4]), .rx_rtr(fl[3]), .rx_err(fl[2]), .rx_filter_ext_sel(fl[1]),
    .rx_filter_match(fl[0]), .rx_filter_hit(rx_filter_hit), .rx_stored(rx_stored),
    .rx_stored_buf(rx_stored_buf), .buf0_full(buf0_full), .buf1_full(buf1_full),
    .rx0_int_flag(rx0_int_flag)
  );
  can_rx_engine_model u_eng (.clk(clk), .rx_valid(rx_valid), .rx_ident(rx_ident),
    .rx_flags(fl), .rx_filter_hit(rx_filter_hit));
  // 40 MHz clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task wrap_up;
    $display("checks %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task chk(input [31:0] seen, input [31:0] exp, input string nm);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // One APB transfer; bounded wait on pready
  task apb(input w, input [31:0] a, input [31:0] d);
    int k;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 16);
    if (pready !== 1'b1) begin
      num_errors++;
      wrap_up;
    end
    rd = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task rchk(input [31:0] a, input [7:0] e, input string nm);
    apb(1'b0, a, 32'h0);
    chk(rd, {24'h0, e}, nm);
  endtask
  task t_reset;
    rchk(`OFS_BUF0_CTRL, 8'h00, "ctrl0");
    rchk(`OFS_BUF1_CTRL, 8'h00, "ctrl1");
    apb(1'b0, 32'h20, 32'h0);
    chk(last_err, 1'b1, "slverr");
    $display("reset test done");
  endtask
  task t_store;
    u_eng.send(29'h5a3, 5'h09, 5'h01);
    rchk(`OFS_BUF0_CTRL, 8'h89, "ctrl0 std");
    rchk(`OFS_B0_ID_HI, 8'hb4, "id hi");
    rchk(`OFS_B0_ID_LO, 8'h70, "id lo");
    u_eng.send(29'h1f00ff11, 5'h13, 5'h00);
    rchk(`OFS_B0_ID_HI, 8'hb4, "id kept");
    apb(1'b1, `OFS_INT_REQ, 32'h0);
    rchk(`OFS_INT_REQ, 8'h01, "int reset");
    chk(rx0_int_flag, 1'b1, "int pin");
    apb(1'b1, `OFS_BUF0_CTRL, 32'h0);
    rchk(`OFS_BUF0_CTRL, 8'h09, "ctrl0 clr");
    apb(1'b1, `OFS_INT_REQ, 32'h0);
    rchk(`OFS_INT_REQ, 8'h00, "int clr");
    chk(rx0_int_flag, 1'b0, "int pin clr");
    $display("store test done");
  endtask
  task t_modes;
    logic [4:0] fr [3];
    logic [11:0] acc;
    fr = '{5'h01, 5'h13, 5'h05};
    acc = 12'he8b;
    for (int m = 0; m < 4; m++) begin
      for (int c = 0; c < 3; c++) begin
        apb(1'b1, `OFS_BUF1_CTRL, {25'h0, m[1:0], 5'h0});
        u_eng.send(29'h3, fr[c], 5'h03);
        apb(1'b0, `OFS_BUF1_CTRL, 32'h0);
        chk(rd[7:5], {acc[m * 3 + c], m[1:0]}, "mode accept");
      end
    end
    $display("mode test done");
  endtask
  task t_double;
    apb(1'b1, `OFS_BUF1_CTRL, 32'h0);
    apb(1'b1, `OFS_BUF0_CTRL, 32'h04);
    u_eng.send(29'h155, 5'h01, 5'h00);
    rchk(`OFS_BUF0_CTRL, 8'h86, "ctrl0 dben");
    u_eng.send(29'h0a5c3e71, 5'h13, 5'h01);
    rchk(`OFS_BUF1_CTRL, 8'h81, "ctrl1 spill");
    rchk(`OFS_B1_ID_HI, 8'h52, "ext hi");
    rchk(`OFS_B1_ID_LO, 8'he8, "ext lo");
    u_eng.send(29'h7ff, 5'h01, 5'h00);
    rchk(`OFS_B0_ID_HI, 8'h2a, "both full");
    apb(1'b1, `OFS_BUF0_CTRL, 32'h0);
    apb(1'b1, `OFS_BUF1_CTRL, 32'h0);
    rchk(`OFS_BUF0_CTRL, 8'h00, "jump off");
    u_eng.send(29'h1, 5'h01, 5'h00);
    u_eng.send(29'h2, 5'h01, 5'h01);
    @(posedge clk);
    chk(buf1_full, 1'b0, "no spill");
    $display("double buffer test done");
  endtask
  task t_enh;
    apb(1'b1, `OFS_FUNC_MODE, 32'h1);
    apb(1'b1, `OFS_BUF0_CTRL, 32'h40);
    u_eng.send(29'h9, 5'h04, 5'h01);
    rchk(`OFS_BUF0_CTRL, 8'hc1, "enh all");
    u_eng.send(29'h7, 5'h1b, 5'h0e);
    rchk(`OFS_BUF1_CTRL, 8'hae, "enh filt");
    apb(1'b1, `OFS_BUF1_CTRL, 32'h0);
    u_eng.send(29'h7, 5'h04, 5'h0e);
    @(posedge clk);
    chk(buf1_full, 1'b0, "enh reject");
    $display("enhanced test done");
  endtask
  // Main sequence
  initial begin
    reset_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 32'h0;
    pwdata = 32'h0;
    num_errors = 0;
    n_tests = 0;
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    t_reset;
    t_store;
    t_modes;
    t_double;
    t_enh;
    wrap_up;
  end
endmodule // can_rx_buffer_status_id_tb_top
